/* File: src/flash_command_protection.sv */
// Command launch, error checking and protection logic of a flash controller.
// Assumes a flash macro on the same clock that answers each request with a
// one-cycle done pulse, and a protection byte valid when reset is released.
//
// Strobed register access was decided locally.
`include "flash_cmd_cfg.svh"
`default_nettype none

module flash_command_protection (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Register port
	input wire flash_cmd_pkg::reg_bus_t reg_bus,
	output logic [7:0] reg_rdata,
	// Stored protection byte
	input wire logic [7:0] eee_prot_nv,
	// Flash macro
	output logic mem_req,
	output flash_cmd_pkg::mem_cmd_t mem_cmd,
	input wire flash_cmd_pkg::mem_resp_t mem_resp,
	// Protection state and command busy
	output logic [2:0] pflash_scenario,
	output logic eee_wp_enable,
	output logic [2:0] eee_wp_size,
	output logic cmd_busy
);
	import flash_cmd_pkg::*;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic in_user(input logic [`ADDR_W-1:0] a);
		in_user = (a >= `DF_BASE) && (a < `DF_EEE_START);
	endfunction

	function automatic logic in_block(input logic [`ADDR_W-1:0] a);
		in_block = (a >= `DF_BASE) && (a <= `DF_END);
	endfunction

	function automatic logic [7:0] pprot_ok(input logic [2:0] from);
		unique case (from)
			3'h0: pprot_ok = `PPROT_OK_0;
			3'h1: pprot_ok = `PPROT_OK_1;
			3'h2: pprot_ok = `PPROT_OK_2;
			3'h3: pprot_ok = `PPROT_OK_3;
			3'h4: pprot_ok = `PPROT_OK_4;
			3'h5: pprot_ok = `PPROT_OK_5;
			3'h6: pprot_ok = `PPROT_OK_6;
			3'h7: pprot_ok = `PPROT_OK_7;
		endcase
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	seq_state_t state_q;
	logic [15:0] param_q [`PARAM_WORDS];
	logic [`IDX_W-1:0] index_q;
	logic [`IDX_W-1:0] launch_idx_q;
	logic command_complete_flag_q;
	logic access_error_flag_q;
	logic verr_q;
	logic vunc_q;
	logic [2:0] pprot_q;
	logic [7:0] eee_write_protection_q;
	logic load_pend_q;
	logic [7:0] rdata_q;
	logic is_erase_q;
	logic wait_q;
	logic [2:0] wcnt_q;
	logic [2:0] nwords_q;
	logic [`ADDR_W-1:0] start_q;
	logic req_q;
	mem_cmd_t cmd_q;
	logic wr_status;
	logic launch;
	logic acc_clr;
	logic param_ok;
	logic [7:0] cmd_code;
	logic [`ADDR_W-1:0] cmd_addr;
	logic [`ADDR_W-1:0] last_addr;
	logic [2:0] prog_words;
	logic prog_err;
	logic erase_err;
	logic check_err;
	logic [7:0] pprot_allowed;
	logic [7:0] eee_write_protection_nx;

	// ****************************************
	// Register decode and launch checks
	// ****************************************
	assign wr_status = reg_bus.write && (reg_bus.addr == `OFS_STATUS);
	assign acc_clr = wr_status && reg_bus.wdata[`ST_ACCESS_ERROR_FLAG];
	// launch by one
	// A launch while an access error is pending is refused, as in the
	// usual flash controllers, so the error cannot be silently lost.
	assign launch = wr_status && reg_bus.wdata[`ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_q &&
		(state_q == ST_IDLE) && !access_error_flag_q && !load_pend_q;
	assign param_ok = (index_q < `IDX_W'(`PARAM_WORDS));

	assign cmd_code = param_q[0][15:8];
	assign cmd_addr = {param_q[0][6:0], param_q[1]};
	assign prog_words = launch_idx_q - 3'h1;
	assign last_addr = cmd_addr + {19'h0_0000, prog_words, 1'b0} -
		`ADDR_W'(2);

	always_comb begin
		prog_err = 1'b0;
		if (launch_idx_q < `IDX_PROG_MIN || launch_idx_q > `IDX_PROG_MAX)
			prog_err = 1'b1;
		if (!in_block(cmd_addr))
			prog_err = 1'b1;
		if (cmd_addr[0])
			prog_err = 1'b1;
		if (cmd_addr >= `DF_EEE_START)
			prog_err = 1'b1;
		if (!in_block(last_addr) || !in_user(last_addr))
			prog_err = 1'b1;
	end

	assign erase_err = (launch_idx_q != `IDX_ERASE) || !in_user(cmd_addr);

	assign check_err = (cmd_code == `CMD_PROG_DF) ? prog_err :
		((cmd_code == `CMD_ERASE_DF) ? erase_err : 1'b1);

	// ****************************************
	// Command sequencer and flash requests
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			launch_idx_q <= 3'h0;
			is_erase_q <= 1'b0;
			start_q <= `ADDR_W'(0);
			nwords_q <= 3'h0;
		end else begin
			unique case (state_q)
				ST_IDLE:
					if (launch) begin
						state_q <= ST_CHECK;
						launch_idx_q <= index_q;
					end
				ST_CHECK: begin
					start_q <= cmd_addr;
					nwords_q <= prog_words;
					is_erase_q <= (cmd_code == `CMD_ERASE_DF);
					if (check_err)
						state_q <= ST_FINISH;
					else
						state_q <= ST_OPER;
				end
				ST_OPER:
					if (wait_q && mem_resp.done &&
						(is_erase_q || wcnt_q == nwords_q - 3'h1))
						state_q <= ST_VERIFY;
				ST_VERIFY:
					if (wait_q && mem_resp.done)
						state_q <= ST_FINISH;
				ST_FINISH: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			req_q <= 1'b0;
			wait_q <= 1'b0;
			wcnt_q <= 3'h0;
			cmd_q <= '0;
		end else begin
			req_q <= 1'b0;
			if (state_q == ST_CHECK) begin
				wait_q <= 1'b0;
				wcnt_q <= 3'h0;
			end else if (state_q == ST_OPER || state_q == ST_VERIFY) begin
				if (!wait_q) begin
					req_q <= 1'b1;
					wait_q <= 1'b1;
					cmd_q.count <= nwords_q;
					if (state_q == ST_VERIFY) begin
						cmd_q.op <= MEM_VERIFY;
						cmd_q.addr <= is_erase_q ?
							(start_q & `DF_SECTOR_MASK) : start_q;
					end else if (is_erase_q) begin
						cmd_q.op <= MEM_ERASE;
						cmd_q.addr <= start_q & `DF_SECTOR_MASK;
					end else begin
						cmd_q.op <= MEM_PROGRAM;
						cmd_q.addr <= start_q +
							{19'h0_0000, wcnt_q, 1'b0};
						cmd_q.wdata <= param_q[wcnt_q + 3'h2];
					end
				end else if (mem_resp.done) begin
					wait_q <= 1'b0;
					if (state_q == ST_OPER && !is_erase_q)
						wcnt_q <= wcnt_q + 3'h1;
				end
			end
		end
	end

	assign mem_req = req_q;
	assign mem_cmd = cmd_q;

	// ****************************************
	// Status flags
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			command_complete_flag_q <= 1'b1;
		end else if (launch) begin
			command_complete_flag_q <= 1'b0;
		end else if (state_q == ST_FINISH) begin
			command_complete_flag_q <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			access_error_flag_q <= 1'b0;
		end else if (state_q == ST_CHECK && check_err) begin
			// error raised; set wins over clear
			access_error_flag_q <= 1'b1;
		end else if (acc_clr) begin
			access_error_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			verr_q <= 1'b0;
			vunc_q <= 1'b0;
		end else if (launch) begin
			verr_q <= 1'b0;
			vunc_q <= 1'b0;
		end else if (state_q == ST_VERIFY && wait_q && mem_resp.done) begin
			verr_q <= mem_resp.verify_err || mem_resp.verify_uncorr;
			vunc_q <= mem_resp.verify_uncorr;
		end
	end

	// ****************************************
	// Parameter array and index
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			index_q <= 3'h0;
		end else if (reg_bus.write && reg_bus.addr == `OFS_INDEX) begin
			index_q <= reg_bus.wdata[`IDX_W-1:0];
		end
	end

	// Writes while a command runs are dropped: the sequencer reads the
	// array directly instead of keeping a private copy.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `PARAM_WORDS; i++)
				param_q[i] <= 16'h0000;
		end else if (reg_bus.write && command_complete_flag_q && param_ok) begin
			if (reg_bus.addr == `OFS_PARAM_HI)
				param_q[index_q][15:8] <= reg_bus.wdata;
			else if (reg_bus.addr == `OFS_PARAM_LO)
				param_q[index_q][7:0] <= reg_bus.wdata;
		end
	end

	// ****************************************
	// Protection registers
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pprot_q <= `PPROT_RESET;
		end else if (reg_bus.write && reg_bus.addr == `OFS_PPROT) begin
			if (pprot_allowed[reg_bus.wdata[2:0]])
				pprot_q <= reg_bus.wdata[2:0];
		end
	end

	assign pprot_allowed = pprot_ok(pprot_q);
	assign pflash_scenario = pprot_q;

	always_comb begin
		eee_write_protection_nx = eee_write_protection_q;
		if (reg_bus.wdata[`EP_OPEN])
			eee_write_protection_nx[`EP_OPEN] = 1'b1;
		if (!reg_bus.wdata[`EP_DIS])
			eee_write_protection_nx[`EP_DIS] = 1'b0;
		if (eee_write_protection_q[`EP_DIS])
			eee_write_protection_nx[`EP_SIZE_HI:0] = reg_bus.wdata[`EP_SIZE_HI:0];
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			load_pend_q <= 1'b1;
		else
			load_pend_q <= 1'b0;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			eee_write_protection_q <= `EEE_WRITE_PROTECTION_RESET;
		end else if (load_pend_q) begin
			eee_write_protection_q <= eee_prot_nv;
		end else if (reg_bus.write && reg_bus.addr == `OFS_EEE_WRITE_PROTECTION) begin
			eee_write_protection_q <= eee_write_protection_nx;
		end
	end

	assign eee_wp_enable = eee_write_protection_q[`EP_OPEN] && !eee_write_protection_q[`EP_DIS];
	assign eee_wp_size = eee_write_protection_q[`EP_OPEN] ?
		eee_write_protection_q[`EP_SIZE_HI:0] : 3'h0;
	assign cmd_busy = !command_complete_flag_q;

	// ****************************************
	// Register reads
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= 8'h00;
			if (reg_bus.read) begin
				unique case (reg_bus.addr)
					`OFS_INDEX: rdata_q <= {5'h00, index_q};
					`OFS_STATUS: begin
						rdata_q[`ST_COMMAND_COMPLETE_FLAG] <= command_complete_flag_q;
						rdata_q[`ST_ACCESS_ERROR_FLAG] <= access_error_flag_q;
						rdata_q[`ST_VERR] <= verr_q;
						rdata_q[`ST_VUNC] <= vunc_q;
					end
					`OFS_PARAM_HI:
						if (param_ok)
							rdata_q <= param_q[index_q][15:8];
					`OFS_PARAM_LO:
						if (param_ok)
							rdata_q <= param_q[index_q][7:0];
					`OFS_PPROT: rdata_q <= {5'h00, pprot_q};
					`OFS_EEE_WRITE_PROTECTION: rdata_q <= eee_write_protection_q;
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

/* File: inc/flash_cmd_cfg.svh */
// Constants for the flash command and protection block.
// Assumes byte-wide register port and a 23-bit global flash address.
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_INDEX 4'h0
`define OFS_STATUS 4'h1
`define OFS_PARAM_HI 4'h2
`define OFS_PARAM_LO 4'h3
`define OFS_PPROT 4'h4
`define OFS_EEE_WRITE_PROTECTION 4'h9

// ****************************************
// Field positions
// ****************************************
`define ST_COMMAND_COMPLETE_FLAG 7
`define ST_ACCESS_ERROR_FLAG 5
`define ST_PVIOL 4
`define ST_VERR 1
`define ST_VUNC 0
`define EP_OPEN 7
`define EP_RNV_HI 6
`define EP_RNV_LO 4
`define EP_DIS 3
`define EP_SIZE_HI 2

// ****************************************
// Widths, codes and reset values
// ****************************************
`define ADDR_W 23
`define PARAM_WORDS 6
`define IDX_W 3
`define CMD_PROG_DF 8'h11
`define CMD_ERASE_DF 8'h12
`define IDX_ERASE 3'h1
`define IDX_PROG_MIN 3'h2
`define IDX_PROG_MAX 3'h5
`define DF_BASE 23'h10_0000
`define DF_END 23'h10_7FFF
`define DF_EEE_START 23'h10_7000
`define DF_SECTOR_MASK 23'h7F_FF00
`define PPROT_RESET 3'h7
`define EEE_WRITE_PROTECTION_RESET 8'hFF
`define PPROT_OK_0 8'h0F
`define PPROT_OK_1 8'h0A
`define PPROT_OK_2 8'h0C
`define PPROT_OK_3 8'h08
`define PPROT_OK_4 8'h18
`define PPROT_OK_5 8'h3C
`define PPROT_OK_6 8'h5A
`define PPROT_OK_7 8'hFF

`endif

/* File: inc/flash_cmd_pkg.sv */
// Types shared by the flash command and protection block.
// Assumes flash_cmd_cfg.svh is on the include path.
`include "flash_cmd_cfg.svh"
`default_nettype none

package flash_cmd_pkg;

	typedef enum logic [1:0] {
		MEM_PROGRAM = 2'h0,
		MEM_ERASE = 2'h1,
		MEM_VERIFY = 2'h2
	} mem_op_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} reg_bus_t;

	typedef struct packed {
		mem_op_t op;
		logic [`ADDR_W-1:0] addr;
		logic [15:0] wdata;
		logic [2:0] count;
	} mem_cmd_t;

	typedef struct packed {
		logic done;
		logic verify_err;
		logic verify_uncorr;
	} mem_resp_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CHECK = 3'h1,
		ST_OPER = 3'h3,
		ST_VERIFY = 3'h2,
		ST_FINISH = 3'h6
	} seq_state_t;

endpackage

`default_nettype wire

/* File: testbench/flash_cmd_monitor.sv */
// Checker for the flash command and protection block.
// Assumes it is bound to flash_command_protection and sees only its ports.
`include "flash_cmd_cfg.svh"
`default_nettype none

module flash_cmd_monitor import flash_cmd_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Register port and stored protection byte
	input wire flash_cmd_pkg::reg_bus_t reg_bus,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] eee_prot_nv,
	// Flash macro
	input wire logic mem_req,
	input wire flash_cmd_pkg::mem_cmd_t mem_cmd,
	input wire flash_cmd_pkg::mem_resp_t mem_resp,
	// Protection state and command busy
	input wire logic [2:0] pflash_scenario,
	input wire logic eee_wp_enable,
	input wire logic [2:0] eee_wp_size,
	input wire logic cmd_busy
);
	// Bit {from,to} set where a scenario move is allowed
	localparam logic [63:0] OK_TBL = 64'hFF5A_3C18_080C_0A0F;
	logic scen_wr;
	logic [2:0] exp_scen_q;
	logic launch_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	assign scen_wr = reg_bus.write && reg_bus.addr == `OFS_PPROT;
	always_ff @(posedge clock) begin
		exp_scen_q <= OK_TBL[{pflash_scenario, reg_bus.wdata[2:0]}] ?
			reg_bus.wdata[2:0] : pflash_scenario;
	end
	always_ff @(posedge clock) begin
		launch_q <= reg_bus.write && reg_bus.addr == `OFS_STATUS &&
			reg_bus.wdata[7];
	end

	// ****
	// Request sequences and assertions
	// ****
	sequence erase_req_s;
		mem_req && mem_cmd.op == MEM_ERASE;
	endsequence
	sequence verify_req_s;
		mem_req && mem_cmd.op == MEM_VERIFY;
	endsequence

	scen_hold_a:
	assert property (!scen_wr |=> $stable(pflash_scenario))
		else $error("scenario moved without a write");
	scen_step_a:
	assert property (scen_wr |=> pflash_scenario == exp_scen_q)
		else $error("scenario move wrong");
	scen_read_a:
	assert property (reg_bus.read && reg_bus.addr == `OFS_PPROT
		|=> reg_rdata[2:0] == $past(pflash_scenario))
		else $error("scenario readback wrong");
	rsvd_bits_a:
	assert property (reg_bus.read && reg_bus.addr == `OFS_EEE_WRITE_PROTECTION
		|=> reg_rdata[6:4] == eee_prot_nv[6:4])
		else $error("reserved bits changed");
	wp_grow_a:
	assert property (!$fell(eee_wp_enable))
		else $error("eeprom protection dropped");
	size_lock_a:
	assert property (eee_wp_enable |=> $stable(eee_wp_size))
		else $error("size moved after lock");
	busy_cause_a:
	assert property ($rose(cmd_busy) |-> launch_q)
		else $error("busy without launch");
	req_busy_a:
	assert property (mem_req |-> cmd_busy)
		else $error("request while idle");
	erase_pair_a:
	assert property (erase_req_s |-> cmd_busy throughout
		(##[1:40] verify_req_s))
		else $error("erase not verified in time");
	erase_align_a:
	assert property (erase_req_s |->
		(mem_cmd.addr & ~`DF_SECTOR_MASK) == 23'h0)
		else $error("erase not sector aligned");
	prog_range_a:
	assert property (mem_req && mem_cmd.op == MEM_PROGRAM |->
		mem_cmd.addr >= `DF_BASE && mem_cmd.addr < `DF_EEE_START &&
		!mem_cmd.addr[0])
		else $error("program outside user data flash");
endmodule

bind flash_command_protection flash_cmd_monitor flash_cmd_monitor_i (
	.clock(clock), .resetn(resetn), .reg_bus(reg_bus),
	.reg_rdata(reg_rdata), .eee_prot_nv(eee_prot_nv),
	.mem_req(mem_req), .mem_cmd(mem_cmd), .mem_resp(mem_resp),
	.pflash_scenario(pflash_scenario), .eee_wp_enable(eee_wp_enable),
	.eee_wp_size(eee_wp_size), .cmd_busy(cmd_busy)
);

`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the flash command and protection block.
// Assumes the flash macro is modelled here with a fixed answer latency.
`include "flash_cmd_cfg.svh"
`default_nettype none

module tb import flash_cmd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [63:0] OK_TBL = 64'hFF5A_3C18_080C_0A0F;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	reg_bus_t reg_bus = '0;
	logic [7:0] reg_rdata;
	logic [7:0] eee_prot_nv = 8'hA9;
	logic mem_req;
	mem_cmd_t mem_cmd;
	mem_resp_t mem_resp = '0;
	logic [2:0] pflash_scenario;
	logic eee_wp_enable;
	logic [2:0] eee_wp_size;
	logic cmd_busy;
	logic [2:0] lat_q = '0;
	logic verr_q = 1'b0;
	logic vunc_q = 1'b0;
	mem_cmd_t log_q[$];
	logic [22:0] bad [4] = '{23'h00_0100, 23'h10_0101, 23'h10_7000,
		23'h10_6FFE};
	int n_errors = 0;
	int checks = 0;

	always #5 clock = ~clock;

	flash_command_protection flash_command_protection_i (
		.clock(clock), .resetn(resetn), .reg_bus(reg_bus),
		.reg_rdata(reg_rdata), .eee_prot_nv(eee_prot_nv),
		.mem_req(mem_req), .mem_cmd(mem_cmd), .mem_resp(mem_resp),
		.pflash_scenario(pflash_scenario), .eee_wp_enable(eee_wp_enable),
		.eee_wp_size(eee_wp_size), .cmd_busy(cmd_busy)
	);

	// ****
	// Flash macro stand-in
	// ****
	// Answer four cycles late so done never lands in the request cycle
	always @(posedge clock) begin
		lat_q <= {lat_q[1:0], mem_req};
		mem_resp.done <= lat_q[2];
		mem_resp.verify_err <= lat_q[2] & verr_q;
		mem_resp.verify_uncorr <= lat_q[2] & vunc_q;
		if (mem_req)
			log_q.push_back(mem_cmd);
	end

	// ****
	// Tasks
	// ****
	task automatic report_and_stop();
		if (n_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [22:0] got, input logic [22:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One idle cycle after each strobe keeps strobes single-cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
		@(posedge clock);
		reg_bus <= '0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		reg_bus <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
		@(posedge clock);
		reg_bus <= '0;
		#1 cmp(reg_rdata, exp);
		@(posedge clock);
	endtask
	task automatic do_reset(input logic [7:0] nv);
		resetn <= 1'b0;
		eee_prot_nv <= nv;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		repeat (2) @(posedge clock);
	endtask
	task automatic put(input logic [2:0] i, input logic [15:0] w);
		wr(`OFS_INDEX, {5'h0, i});
		wr(`OFS_PARAM_HI, w[15:8]);
		wr(`OFS_PARAM_LO, w[7:0]);
	endtask
	task automatic run(input logic [7:0] code, input logic [22:0] a,
		input int n);
		int i;
		put(3'h0, {code, 1'b0, a[22:16]});
		put(3'h1, a[15:0]);
		for (int k = 0; k < n; k++)
			put(3'(2 + k), 16'hC0DE + 16'(k));
		wr(`OFS_INDEX, 8'(1 + n));
		wr(`OFS_STATUS, 8'h80);
		for (i = 0; i < 60 && cmd_busy !== 1'b0; i++)
			@(posedge clock);
		if (i == 60) begin
			cmp(cmd_busy, 23'h0);
			report_and_stop();
		end
	endtask

	// ****
	// Scenarios
	// ****
	initial begin
		do_reset(8'hA9);
		rd(`OFS_EEE_WRITE_PROTECTION, 8'hA9);
		rd(`OFS_PPROT, 8'h07);
		rd(4'hF, 8'h00);
		wr(`OFS_EEE_WRITE_PROTECTION, 8'h8D);
		rd(`OFS_EEE_WRITE_PROTECTION, 8'hAD);
		wr(`OFS_EEE_WRITE_PROTECTION, 8'h05);
		rd(`OFS_EEE_WRITE_PROTECTION, 8'hA5);
		cmp(eee_wp_enable, 23'h1);
		wr(`OFS_EEE_WRITE_PROTECTION, 8'h8A);
		rd(`OFS_EEE_WRITE_PROTECTION, 8'hA5);
		cmp(eee_wp_size, 23'h5);
		run(8'h12, 23'h10_0234, 0);
		rd(`OFS_STATUS, 8'h80);
		cmp(log_q.size(), 23'h2);
		cmp(log_q[0].addr, 23'h10_0200);
		cmp(log_q[1].op, MEM_VERIFY);
		verr_q <= 1'b1;
		vunc_q <= 1'b1;
		run(`CMD_PROG_DF, 23'h10_0100, 2);
		rd(`OFS_STATUS, 8'h83);
		cmp(log_q[3].addr, 23'h10_0102);
		cmp(log_q[3].wdata, 23'hC0DF);
		cmp(log_q[4].count, 23'h2);
		verr_q <= 1'b0;
		vunc_q <= 1'b0;
		run(`CMD_PROG_DF, 23'h10_0100, 4);
		rd(`OFS_STATUS, 8'h80);
		foreach (bad[i]) begin
			run(`CMD_PROG_DF, bad[i], 2);
			rd(`OFS_STATUS, 8'hA0);
			wr(`OFS_STATUS, 8'h20);
			rd(`OFS_STATUS, 8'h80);
		end
		cmp(log_q.size(), 23'hA);
		do_reset(8'h0F);
		cmp(eee_wp_size, 23'h0);
		wr(`OFS_EEE_WRITE_PROTECTION, 8'h8F);
		rd(`OFS_EEE_WRITE_PROTECTION, 8'h8F);
		cmp(eee_wp_size, 23'h7);
		for (int f = 0; f < 8; f++)
			for (int t = 0; t < 8; t++) begin
				do_reset(8'hA9);
				wr(`OFS_PPROT, 8'(f));
				wr(`OFS_PPROT, 8'(t));
				rd(`OFS_PPROT, OK_TBL[f * 8 + t] ? 8'(t) : 8'(f));
			end
		report_and_stop();
	end
endmodule

`default_nettype wire
